// ==== event_flags_pkg.sv ====
package event_flags_pkg;

    // Serial frame bytes.
    localparam logic [7:0] FRAME_HEADER = 8'hFF;
    localparam logic [7:0] FRAME_ESCAPE = 8'hFE;
    localparam logic [7:0] REPLY_ACK = 8'h06;
    localparam logic [7:0] REPLY_NACK = 8'h15;
    localparam logic [7:0] SIZE_SHORT = 8'h03;
    localparam logic [7:0] SIZE_LONG = 8'h04;
    localparam logic [7:0] VOLATILE_BIT = 8'h80;

    // Volatile register addresses.
    localparam logic [7:0] ADDR_SECURITY_KEY_STATUS = 8'hC9;
    localparam logic [7:0] ADDR_PAIRING_PROGRESS_STATUS = 8'hCA;
    localparam logic [7:0] ADDR_FLAGS_HIGH = 8'hCD;
    localparam logic [7:0] ADDR_FLAGS_MID = 8'hCE;
    localparam logic [7:0] ADDR_FLAGS_LOW = 8'hCF;
    localparam logic [7:0] ADDR_COMMAND = 8'hC7;

    // Command register values.
    localparam logic [7:0] CMD_CLEAR_INPUT_BUFFER = 8'h07;
    localparam logic [7:0] CMD_PAIRING_CONTROL = 8'h10;
    localparam logic [7:0] PAIRING_SUB_HALT = 8'h00;

    // Field positions.
    localparam int KEY_VOLATILE_BIT = 1;
    localparam int KEY_NONVOLATILE_BIT = 2;
    localparam int LOW_WRITE_FAIL_BIT = 2;
    localparam int MID_TX_DONE_BIT = 0;
    localparam int MID_RX_WAIT_BIT = 1;
    localparam int MID_PLAINTEXT_BIT = 2;
    localparam int MID_SEQ_DEC_BIT = 3;
    localparam int MID_SEQ_GAP_BIT = 4;
    localparam int MID_PAIRING_BIT = 5;
    localparam logic [7:0] MID_USED_MASK = 8'h3F;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    // One-cycle event pulses, except ack_enabled, which is held as a level; the last member of a packed struct lands on flag bit 0.
    typedef struct packed {
        logic unsupported_frame;
        logic acknowledge_sequence_error;
        logic header_crc_error;
        logic payload_crc_error;
        logic missing_acknowledge;
        logic register_write_failure;
        logic radio_buffer_overflow;
        logic serial_buffer_overflow;
    } low_events_s;

    typedef struct packed {
        logic packet_sent;
        logic ack_enabled;
        logic ack_received;
        logic plaintext_packet;
        logic encrypted_packet;
        logic pairing_started;
    } link_events_s;

    typedef enum logic [2:0] {
        ST_HEADER,
        ST_SIZE,
        ST_ESCAPE,
        ST_ADDR_OR_ESC,
        ST_READ_ADDR,
        ST_VALUE,
        ST_VALUE2
    } frame_state_e;

endpackage : event_flags_pkg

// ==== event_flags.sv ====
`timescale 1ns/1ns
module event_flags
    import event_flags_pkg::*;
#(
    parameter int SEQ_W = 16
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Command byte stream from the serial receiver.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    output logic cmd_ready,
    // Reply byte stream to the serial transmitter.
    output logic reply_valid,
    output logic [7:0] reply_byte,
    input wire logic reply_ready,
    // Writes to registers held elsewhere.
    output logic reg_write_valid,
    output logic [7:0] reg_write_addr,
    output logic [7:0] reg_write_data,
    // Commands issued to the radio core.
    output logic clear_input_buffer_command,
    output logic pairing_control_command,
    output logic [7:0] pairing_subcommand,
    // Status and events from the radio core.
    input wire logic volatile_key_loaded,
    input wire logic nonvolatile_key_loaded,
    input wire logic [7:0] pairing_progress,
    input wire logic pairing_active,
    input wire logic accept_plaintext_enable,
    input wire logic receive_bytes_pending,
    input wire low_events_s low_events,
    input wire link_events_s link_events,
    input wire logic [SEQ_W-1:0] packet_sequence,
    // Masks and alert.
    input wire logic [7:0] extended_event_mask_high,
    input wire logic [7:0] extended_event_mask_mid,
    input wire logic [7:0] extended_event_mask_low,
    input wire logic [7:0] legacy_event_mask,
    output logic event_alert_line
);

    if (SEQ_W < 2 || SEQ_W > 32) begin : g_bad_seq
        $error("SEQ_W must lie between 2 and 32");
    end

    function automatic logic [7:0] volatile_addr(input logic [7:0] a);
        return a | VOLATILE_BIT;
    endfunction : volatile_addr

    frame_state_e state_reg;
    logic [7:0] size_reg;
    logic [7:0] addr_reg;
    logic [7:0] value_reg;
    logic is_read_reg;
    logic [7:0] flags_low_reg;
    logic [7:0] flags_mid_reg;
    logic [7:0] flags_high_reg;
    logic [7:0] reply_mem_reg [3];
    logic [1:0] reply_count_reg;
    logic [1:0] reply_index_reg;
    logic [SEQ_W-1:0] last_seq_reg;
    logic seq_seen_reg;

    logic byte_take;
    logic frame_done;
    logic [7:0] target;
    logic is_flag_low;
    logic is_flag_mid;
    logic is_flag_high;
    logic is_halt;
    logic write_refused;
    logic write_ok;
    logic [7:0] read_value;
    logic read_mapped;
    logic [7:0] low_keep;
    logic [7:0] mid_keep;
    logic [7:0] low_set;
    logic [7:0] mid_set;
    logic mid_internal_clear;

    assign cmd_ready = (reply_count_reg == 2'd0);
    assign byte_take = cmd_valid && cmd_ready;
    assign reply_valid = (reply_count_reg != 2'd0);
    assign reply_byte = reply_mem_reg[reply_index_reg];

    // A frame ends on the last value byte of a write (the second one for a long frame) or the address byte of a read.
    assign frame_done = byte_take && ((state_reg == ST_READ_ADDR)
        || (state_reg == ST_VALUE && size_reg == SIZE_SHORT)
        || state_reg == ST_VALUE2);
    assign target = volatile_addr(addr_reg);
    assign is_flag_low = (target == ADDR_FLAGS_LOW);
    assign is_flag_mid = (target == ADDR_FLAGS_MID);
    assign is_flag_high = (target == ADDR_FLAGS_HIGH);
    assign is_halt = (target == ADDR_COMMAND) && (value_reg == CMD_PAIRING_CONTROL)
        && (cmd_byte == PAIRING_SUB_HALT) && (state_reg == ST_VALUE2);
    assign write_refused = frame_done && !is_read_reg && pairing_active && !is_halt;
    assign write_ok = frame_done && !is_read_reg && !write_refused;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_HEADER;
            size_reg <= FLAGS_RESET;
            addr_reg <= FLAGS_RESET;
            value_reg <= FLAGS_RESET;
            is_read_reg <= 1'b0;
        end else if (byte_take) begin
            case (state_reg)
                ST_HEADER: begin
                    if (cmd_byte == FRAME_HEADER) begin
                        state_reg <= ST_SIZE;
                    end
                end
                ST_SIZE: begin
                    size_reg <= cmd_byte;
                    if (cmd_byte == SIZE_SHORT || cmd_byte == SIZE_LONG) begin
                        state_reg <= ST_ESCAPE;
                    end else begin
                        state_reg <= ST_HEADER;
                    end
                end
                ST_ESCAPE: begin
                    state_reg <= (cmd_byte == FRAME_ESCAPE) ? ST_ADDR_OR_ESC : ST_HEADER;
                end
                ST_ADDR_OR_ESC: begin
                    if (cmd_byte == FRAME_ESCAPE) begin
                        is_read_reg <= 1'b1;
                        state_reg <= ST_READ_ADDR;
                    end else begin
                        is_read_reg <= 1'b0;
                        addr_reg <= cmd_byte;
                        state_reg <= ST_VALUE;
                    end
                end
                ST_READ_ADDR: begin
                    addr_reg <= cmd_byte;
                    state_reg <= ST_HEADER;
                end
                ST_VALUE: begin
                    value_reg <= cmd_byte;
                    state_reg <= (size_reg == SIZE_LONG) ? ST_VALUE2 : ST_HEADER;
                end
                ST_VALUE2: begin
                    state_reg <= ST_HEADER;
                end
                default: begin
                    state_reg <= ST_HEADER;
                end
            endcase
        end
    end

    // Read decode uses the incoming address byte, since addr_reg updates at the same edge.
    always_comb begin
        read_mapped = 1'b1;
        case (volatile_addr(cmd_byte))
            ADDR_SECURITY_KEY_STATUS: begin
                read_value = FLAGS_RESET;
                read_value[KEY_VOLATILE_BIT] = volatile_key_loaded;
                read_value[KEY_NONVOLATILE_BIT] = nonvolatile_key_loaded;
            end
            ADDR_PAIRING_PROGRESS_STATUS: read_value = pairing_progress;
            ADDR_FLAGS_HIGH: read_value = flags_high_reg;
            ADDR_FLAGS_MID: read_value = flags_mid_reg;
            ADDR_FLAGS_LOW: read_value = flags_low_reg;
            default: begin
                read_value = FLAGS_RESET;
                read_mapped = 1'b0;
            end
        endcase
    end

    // Replies: ACK, address and value for a mapped read, a single NACK for an unmapped one; a single ACK or NACK for a write.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reply_count_reg <= 2'd0;
            reply_index_reg <= 2'd0;
            for (int i = 0; i < 3; i++) begin
                reply_mem_reg[i] <= FLAGS_RESET;
            end
        end else if (frame_done && is_read_reg) begin
            reply_index_reg <= 2'd0;
            if (read_mapped) begin
                reply_mem_reg[0] <= REPLY_ACK;
                reply_mem_reg[1] <= volatile_addr(cmd_byte);
                reply_mem_reg[2] <= read_value;
                reply_count_reg <= 2'd3;
            end else begin
                reply_mem_reg[0] <= REPLY_NACK;
                reply_count_reg <= 2'd1;
            end
        end else if (frame_done) begin
            reply_index_reg <= 2'd0;
            reply_mem_reg[0] <= write_refused ? REPLY_NACK : REPLY_ACK;
            reply_count_reg <= 2'd1;
        end else if (reply_valid && reply_ready) begin
            reply_count_reg <= reply_count_reg - 2'd1;
            reply_index_reg <= reply_index_reg + 2'd1;
        end
    end

    // Accepted writes to registers held outside, and commands to the radio core.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_write_valid <= 1'b0;
            reg_write_addr <= FLAGS_RESET;
            reg_write_data <= FLAGS_RESET;
            clear_input_buffer_command <= 1'b0;
            pairing_control_command <= 1'b0;
            pairing_subcommand <= FLAGS_RESET;
        end else begin
            reg_write_valid <= write_ok && !is_flag_low && !is_flag_mid && !is_flag_high
                && (target != ADDR_COMMAND);
            reg_write_addr <= target;
            reg_write_data <= (state_reg == ST_VALUE2) ? value_reg : cmd_byte;
            clear_input_buffer_command <= write_ok && (target == ADDR_COMMAND)
                && (state_reg == ST_VALUE) && (cmd_byte == CMD_CLEAR_INPUT_BUFFER);
            pairing_control_command <= write_ok && (target == ADDR_COMMAND)
                && (state_reg == ST_VALUE2) && (value_reg == CMD_PAIRING_CONTROL);
            if (state_reg == ST_VALUE2 && byte_take) begin
                pairing_subcommand <= cmd_byte;
            end
        end
    end

    // Sequence history for encrypted packets.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_seq_reg <= '0;
            seq_seen_reg <= 1'b0;
        end else if (link_events.encrypted_packet) begin
            last_seq_reg <= packet_sequence;
            seq_seen_reg <= 1'b1;
        end
    end

    always_comb begin
        low_set = low_events;
        low_set[LOW_WRITE_FAIL_BIT] = low_events.register_write_failure || write_refused;
        mid_set = FLAGS_RESET;
        mid_set[MID_TX_DONE_BIT] = (link_events.packet_sent && !link_events.ack_enabled)
            || link_events.ack_received;
        mid_set[MID_RX_WAIT_BIT] = receive_bytes_pending
            && !clear_input_buffer_command;
        mid_set[MID_PLAINTEXT_BIT] = link_events.plaintext_packet
            && accept_plaintext_enable;
        mid_set[MID_SEQ_DEC_BIT] = link_events.encrypted_packet && seq_seen_reg
            && (packet_sequence < last_seq_reg);
        mid_set[MID_SEQ_GAP_BIT] = link_events.encrypted_packet && seq_seen_reg
            && (packet_sequence > last_seq_reg)
            && ((packet_sequence - last_seq_reg) > SEQ_W'(1));
        mid_set[MID_PAIRING_BIT] = link_events.pairing_started;
        mid_internal_clear = !receive_bytes_pending || clear_input_buffer_command;
        low_keep = (write_ok && is_flag_low) ? cmd_byte : ALL_ONES;
        mid_keep = (write_ok && is_flag_mid) ? cmd_byte : ALL_ONES;
        mid_keep[MID_RX_WAIT_BIT] = mid_keep[MID_RX_WAIT_BIT] && !mid_internal_clear;
    end

    // The set term is ORed after the AND, so an event never loses to a clear.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags_low_reg <= FLAGS_RESET;
            flags_mid_reg <= FLAGS_RESET;
            flags_high_reg <= FLAGS_RESET;
        end else begin
            flags_low_reg <= (flags_low_reg & low_keep) | low_set;
            flags_mid_reg <= ((flags_mid_reg & mid_keep) | mid_set) & MID_USED_MASK;
            flags_high_reg <= FLAGS_RESET;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            event_alert_line <= 1'b0;
        end else begin
            event_alert_line <= (legacy_event_mask == FLAGS_RESET)
                && (|(flags_low_reg & extended_event_mask_low)
                || |(flags_mid_reg & extended_event_mask_mid)
                || |(flags_high_reg & extended_event_mask_high));
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_alert_follows_mask: assert property (
        ##1 event_alert_line == $past((legacy_event_mask == FLAGS_RESET)
            && |(flags_low_reg & extended_event_mask_low)
            || (legacy_event_mask == FLAGS_RESET)
            && |(flags_mid_reg & extended_event_mask_mid)))
        else $error("alert line does not follow masked flags");
    a_event_sets_low: assert property (
        low_events.payload_crc_error |=> flags_low_reg[4])
        else $error("crc event did not set its flag");
    a_no_write_set: assert property (
        $rose(flags_low_reg[0]) |-> $past(low_events.serial_buffer_overflow))
        else $error("flag set without an event");
    a_and_write: assert property (
        (write_ok && is_flag_low && low_set == FLAGS_RESET)
        |=> flags_low_reg == ($past(flags_low_reg) & $past(cmd_byte)))
        else $error("flag write is not an AND");
    a_read_keeps: assert property (
        (frame_done && is_read_reg && low_set == FLAGS_RESET)
        |=> flags_low_reg == $past(flags_low_reg))
        else $error("read disturbed the flags");
    a_high_zero: assert property (flags_high_reg == FLAGS_RESET)
        else $error("reserved flag byte not zero");
    a_rx_wait_level: assert property (
        ##1 flags_mid_reg[MID_RX_WAIT_BIT]
            == $past(receive_bytes_pending && !clear_input_buffer_command))
        else $error("receive waiting flag wrong");
    a_pairing_refuses: assert property (
        (frame_done && !is_read_reg && pairing_active && !is_halt)
        |=> reply_mem_reg[0] == REPLY_NACK && !reg_write_valid
            && flags_low_reg[LOW_WRITE_FAIL_BIT])
        else $error("write not refused during pairing");
    a_read_reply: assert property (
        (frame_done && is_read_reg && volatile_addr(cmd_byte) == ADDR_SECURITY_KEY_STATUS)
        |=> reply_count_reg == 2'd3 && reply_mem_reg[0] == REPLY_ACK
            && reply_mem_reg[1] == ADDR_SECURITY_KEY_STATUS)
        else $error("security status reply malformed");
    a_plaintext_gated: assert property (
        (link_events.plaintext_packet && !accept_plaintext_enable
            && !flags_mid_reg[MID_PLAINTEXT_BIT])
        |=> !flags_mid_reg[MID_PLAINTEXT_BIT])
        else $error("plaintext flag set while disabled");

    c_read_frame: cover property (frame_done && is_read_reg);
    c_clear_write: cover property (write_ok && is_flag_mid);
    c_refused: cover property (write_refused);
    c_alert: cover property ($rose(event_alert_line));

endmodule : event_flags

// ==== host_model.sv ====
`timescale 1ns/1ns
module host_model (
    // Clock.
    input wire logic clock,
    // Command byte stream.
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    input wire logic cmd_ready,
    // Reply byte stream.
    input wire logic reply_valid,
    input wire logic [7:0] reply_byte,
    output logic reply_ready,
    // Stall control.
    input wire logic slow
);
    logic [7:0] replies[$];

    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        reply_ready = 1'b1;
    end

    // A slow host takes reply bytes on every other cycle only.
    always @(posedge clock) begin
        if (reply_valid && reply_ready) begin
            replies.push_back(reply_byte);
        end
        reply_ready <= slow ? !reply_ready : 1'b1;
    end

    // Each byte is held until the edge that finds the block ready; the released
    // byte lane shows the inverse so that a stale value is never mistaken for data.
    task automatic xfer(input logic [7:0] f[$], input int n, output logic ok);
        int w;
        replies.delete();
        @(posedge clock);
        foreach (f[i]) begin
            cmd_valid <= 1'b1;
            cmd_byte <= f[i];
            w = 0;
            do begin
                @(posedge clock);
                w++;
            end while (!cmd_ready && w < 100);
        end
        cmd_valid <= 1'b0;
        cmd_byte <= ~f[f.size() - 1];
        w = 0;
        while (replies.size() < n && w < 200) begin
            @(posedge clock);
            w++;
        end
        ok = (replies.size() == n);
    endtask : xfer
endmodule : host_model

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
    import event_flags_pkg::*;
    logic clock, resetn, cmd_valid, cmd_ready, reply_valid, reply_ready, slow;
    logic reg_write_valid, clear_input_buffer_command, pairing_control_command;
    logic volatile_key_loaded, nonvolatile_key_loaded, pairing_active;
    logic accept_plaintext_enable, receive_bytes_pending, event_alert_line;
    logic [7:0] cmd_byte, reply_byte, reg_write_addr, reg_write_data, pairing_subcommand;
    logic [7:0] pairing_progress, mask_high, mask_mid, mask_low, legacy;
    logic [5:0] keep;
    low_events_s low_events;
    link_events_s link_events;
    logic [15:0] packet_sequence;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_clear = 0;
    int n_halt = 0;
    int n_reg_write = 0;
    logic [15:0] last_wr = '0;
    logic [15:0] packet_sequence_list[4] = '{16'h000A, 16'h000B, 16'h0009, 16'h000C};
    logic [7:0] flags_list[4] = '{8'h04, 8'h04, 8'h0C, 8'h1C};

    event_flags #(.SEQ_W(16)) dut (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .reply_valid(reply_valid),
        .reply_byte(reply_byte), .reply_ready(reply_ready), .reg_write_valid(reg_write_valid),
        .reg_write_addr(reg_write_addr), .reg_write_data(reg_write_data),
        .clear_input_buffer_command(clear_input_buffer_command),
        .pairing_control_command(pairing_control_command),
        .pairing_subcommand(pairing_subcommand), .volatile_key_loaded(volatile_key_loaded),
        .nonvolatile_key_loaded(nonvolatile_key_loaded), .pairing_progress(pairing_progress),
        .pairing_active(pairing_active), .accept_plaintext_enable(accept_plaintext_enable),
        .receive_bytes_pending(receive_bytes_pending), .low_events(low_events),
        .link_events(link_events), .packet_sequence(packet_sequence),
        .extended_event_mask_high(mask_high), .extended_event_mask_mid(mask_mid),
        .extended_event_mask_low(mask_low), .legacy_event_mask(legacy),
        .event_alert_line(event_alert_line));

    host_model host (.clock(clock), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply_byte(reply_byte),
        .reply_ready(reply_ready), .slow(slow));

    initial begin
        clock = 1'b0;
        forever #25 clock = !clock;
    end

    always @(posedge clock) begin
        n_clear += clear_input_buffer_command;
        n_halt += pairing_control_command && pairing_subcommand === PAIRING_SUB_HALT;
        if (reg_write_valid === 1'b1) begin
            n_reg_write++;
            last_wr = {reg_write_addr, reg_write_data};
        end
    end

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // A lost reply means the frame engine hung, so the run ends at once.
    task automatic xf(input logic [7:0] f[$], input int n);
        logic ok;
        host.xfer(f, n, ok);
        check(ok, 1'b1);
        if (!ok) begin
            complete_run();
        end
    endtask : xf

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        xf('{FRAME_HEADER, SIZE_SHORT, FRAME_ESCAPE, FRAME_ESCAPE, a ^ VOLATILE_BIT}, 3);
        check({host.replies[0], host.replies[1], host.replies[2]}, {REPLY_ACK, a, exp});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] rep);
        xf('{FRAME_HEADER, SIZE_SHORT, FRAME_ESCAPE, a ^ VOLATILE_BIT, v}, 1);
        check(host.replies[0], rep);
    endtask : wr

    // Link bits: 20 sent, 10 ack enabled, 08 ack received, 04 plaintext, 02 encrypted,
    // 01 pairing started.
    task automatic pulse(input logic [7:0] lo, input logic [5:0] li);
        @(posedge clock);
        low_events <= low_events_s'(lo);
        link_events <= link_events_s'(li | keep);
        @(posedge clock);
        low_events <= '0;
        link_events <= link_events_s'(keep);
        tick(3);
    endtask : pulse

    task automatic t_status;
        slow <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            volatile_key_loaded <= i[0];
            nonvolatile_key_loaded <= i[1];
            rd(ADDR_SECURITY_KEY_STATUS, {5'h00, i[1], i[0], 1'b0});
        end
        pairing_progress <= 8'h5A;
        rd(ADDR_PAIRING_PROGRESS_STATUS, 8'h5A);
        slow <= 1'b0;
    endtask : t_status

    task automatic t_low;
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i, 6'h00);
            rd(ADDR_FLAGS_LOW, 8'((2 << i) - 1));
        end
        rd(ADDR_FLAGS_LOW, 8'hFF);
        wr(ADDR_FLAGS_LOW, 8'hF0, REPLY_ACK);
        rd(ADDR_FLAGS_LOW, 8'hF0);
        wr(ADDR_FLAGS_LOW, 8'hFF, REPLY_ACK);
        rd(ADDR_FLAGS_LOW, 8'hF0);
        wr(ADDR_FLAGS_LOW, 8'h00, REPLY_ACK);
        rd(ADDR_FLAGS_HIGH, 8'h00);
    endtask : t_low

    task automatic t_alert;
        mask_low <= 8'h01;
        tick(3);
        check(event_alert_line, 1'b0);
        pulse(8'h01, 6'h00);
        check(event_alert_line, 1'b1);
        legacy <= 8'h01;
        tick(3);
        check(event_alert_line, 1'b0);
        legacy <= 8'h00;
        wr(ADDR_FLAGS_LOW, 8'hFE, REPLY_ACK);
        tick(3);
        check(event_alert_line, 1'b0);
    endtask : t_alert

    task automatic t_link;
        pulse(8'h00, 6'h20);
        rd(ADDR_FLAGS_MID, 8'h01);
        wr(ADDR_FLAGS_MID, 8'h00, REPLY_ACK);
        keep = 6'h10;
        pulse(8'h00, 6'h20);
        rd(ADDR_FLAGS_MID, 8'h00);
        pulse(8'h00, 6'h08);
        rd(ADDR_FLAGS_MID, 8'h01);
        keep = 6'h00;
        wr(ADDR_FLAGS_MID, 8'hFE, REPLY_ACK);
        pulse(8'h00, 6'h04);
        rd(ADDR_FLAGS_MID, 8'h00);
        accept_plaintext_enable <= 1'b1;
        pulse(8'h00, 6'h04);
        rd(ADDR_FLAGS_MID, 8'h04);
        foreach (packet_sequence_list[i]) begin
            packet_sequence <= packet_sequence_list[i];
            pulse(8'h00, 6'h02);
            rd(ADDR_FLAGS_MID, flags_list[i]);
        end
        pulse(8'h00, 6'h01);
        rd(ADDR_FLAGS_MID, 8'h3C);
        receive_bytes_pending <= 1'b1;
        tick(3);
        wr(ADDR_FLAGS_MID, 8'h00, REPLY_ACK);
        rd(ADDR_FLAGS_MID, 8'h02);
        wr(ADDR_COMMAND, CMD_CLEAR_INPUT_BUFFER, REPLY_ACK);
        receive_bytes_pending <= 1'b0;
        tick(3);
        check(n_clear, 1);
        rd(ADDR_FLAGS_MID, 8'h00);
    endtask : t_link

    task automatic t_pairing;
        pairing_active <= 1'b1;
        wr(ADDR_FLAGS_LOW, 8'h00, REPLY_NACK);
        wr(8'hD4, 8'h20, REPLY_NACK);
        rd(ADDR_FLAGS_LOW, 8'h04);
        xf('{FRAME_HEADER, SIZE_LONG, FRAME_ESCAPE, ADDR_COMMAND ^ VOLATILE_BIT,
            CMD_PAIRING_CONTROL, PAIRING_SUB_HALT}, 1);
        tick(2);
        check({host.replies[0], 8'(n_halt)}, {REPLY_ACK, 8'h01});
        pairing_active <= 1'b0;
        wr(ADDR_FLAGS_LOW, 8'hFB, REPLY_ACK);
        rd(ADDR_FLAGS_LOW, 8'h00);
        // Only the write made after pairing ends may reach the outside registers.
        wr(8'hD4, 8'h20, REPLY_ACK);
        tick(2);
        check({8'(n_reg_write), last_wr}, {8'h01, 8'hD4, 8'h20});
    endtask : t_pairing

    initial begin
        {resetn, slow, volatile_key_loaded, nonvolatile_key_loaded, pairing_active} = '0;
        {accept_plaintext_enable, receive_bytes_pending, keep} = '0;
        {pairing_progress, mask_high, mask_mid, mask_low, legacy} = '0;
        low_events = '0;
        link_events = '0;
        packet_sequence = '0;
        tick(10);
        resetn <= 1'b1;
        mask_high <= 8'hFF;
        rd(ADDR_FLAGS_HIGH, 8'h00);
        rd(ADDR_FLAGS_MID, 8'h00);
        rd(ADDR_FLAGS_LOW, 8'h00);
        check(event_alert_line, 1'b0);
        t_status();
        t_low();
        t_alert();
        t_link();
        t_pairing();
        complete_run();
    end
endmodule : tb
